// ### include/rdsl_pkg.sv
// Purpose: Shared constants, types and register map of the roll diameter block.
// Assumes: 40 MHz clock; APB register word index times four gives the byte address.
// Notes:   Diameters in mm, rate in 0.01 mm/s, thickness in 0.001 mm.
package rdsl_pkg;
	// ************************************************************
	// Register indices (byte address is four times the index).
	// ************************************************************
	localparam logic [15:0] IDX_METHOD   = 16'h502C;
	localparam logic [15:0] IDX_MAX_D    = 16'h502D;
	localparam logic [15:0] IDX_SHAFT    = 16'h502E;
	localparam logic [15:0] IDX_INIT_SRC = 16'h502F;
	localparam logic [15:0] IDX_SP1      = 16'h5030;
	localparam logic [15:0] IDX_SP2      = 16'h5031;
	localparam logic [15:0] IDX_SP3      = 16'h5032;
	localparam logic [15:0] IDX_RST_MODE = 16'h5033;
	localparam logic [15:0] IDX_RATE     = 16'h5036;
	localparam logic [15:0] IDX_DIR_LIM  = 16'h5037;
	localparam logic [15:0] IDX_MIN_LS   = 16'h503B;
	localparam logic [15:0] IDX_MIN_F    = 16'h503F;
	localparam logic [15:0] IDX_THICK    = 16'h5044;
	localparam logic [15:0] IDX_STATUS   = 16'h5048;
	localparam logic [15:0] IDX_SERIAL_D = 16'h300C;
	localparam int          ADDR_W       = 18;

	// ************************************************************
	// Reset values.
	// ************************************************************
	localparam logic [15:0] RST_METHOD   = 16'h0000;
	localparam logic [15:0] RST_MAX_D    = 16'h01F4;
	localparam logic [15:0] RST_SHAFT    = 16'h0064;
	localparam logic [15:0] RST_INIT_SRC = 16'h0000;
	localparam logic [15:0] RST_SP       = 16'h0064;
	localparam logic [15:0] RST_RST_MODE = 16'h0000;
	localparam logic [15:0] RST_RATE     = 16'h03E8;
	localparam logic [15:0] MAX_RATE     = 16'h4E20;
	localparam logic [15:0] RST_DIR_LIM  = 16'h0000;
	localparam logic [15:0] RST_MIN_LS   = 16'h0014;
	localparam logic [15:0] RST_MIN_F    = 16'h0064;
	localparam logic [15:0] RST_THICK    = 16'h0064;
	localparam logic [15:0] MIN_DIAM     = 16'h0001;

	// ************************************************************
	// Codes of the two source selectors.
	// ************************************************************
	localparam logic [3:0] M_FIXED  = 4'h0;
	localparam logic [3:0] M_LINE   = 4'h1;
	localparam logic [3:0] M_THICK  = 4'h2;
	localparam logic [3:0] M_AIN1   = 4'h4;
	localparam logic [3:0] M_AIN2   = 4'h5;
	localparam logic [3:0] M_PULSE  = 4'h7;
	localparam logic [3:0] M_SERIAL = 4'h8;
	localparam logic [3:0] I_TERM   = 4'h0;
	localparam logic [3:0] I_AIN1   = 4'h2;
	localparam logic [3:0] I_AIN2   = 4'h3;
	localparam logic [3:0] I_PULSE  = 4'h5;

	// ************************************************************
	// Timing and scaling.
	// ************************************************************
	localparam int          CLK_HZ      = 40000000;
	localparam int          TICK_MS     = 10;
	localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
	localparam logic [31:0] FRAC        = 32'h0000_2710;
	localparam logic [31:0] THICK_SCALE = 32'h0000_0014;
	localparam int          AIN_FS      = 4095;
	localparam int          PUL_FS      = 50000;
	localparam int          LS_GAIN     = 53;

	typedef struct packed {
		logic [15:0] method;
		logic [15:0] max_d;
		logic [15:0] shaft;
		logic [15:0] init_src;
		logic [15:0] sp1;
		logic [15:0] sp2;
		logic [15:0] sp3;
		logic [15:0] rst_mode;
		logic [15:0] rate;
		logic [15:0] dir_lim;
		logic [15:0] min_ls;
		logic [15:0] min_f;
		logic [15:0] thick;
		logic [15:0] serial_d;
	} rdsl_cfg_t;
endpackage : rdsl_pkg

// ### rtl/rdsl_div.sv
// Purpose: Sequential unsigned restoring divider.
// Assumes: Divisor is non-zero when start is raised.
// Notes:   One quotient bit per clock; result valid with done.
`timescale 1ns/1ps
`default_nettype none
module rdsl_div
	import rdsl_pkg::*;
#(
	parameter int NW = 32,
	parameter int DW = 16
)(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic [NW-1:0] num,
	input  wire logic [DW-1:0] den,
	output var  logic [NW-1:0] quot_q,
	output var  logic          done_q
);
	typedef enum logic [0:0] {
		RDSL_D_IDLE = 1'b0,
		RDSL_D_BUSY = 1'b1
	} rdsl_div_st_t;

	rdsl_div_st_t  st_q;
	logic [DW:0]   rem_q;
	logic [NW-1:0] n_q;
	logic [7:0]    cnt_q;
	logic [DW:0]   trial;
	logic [DW-1:0] d_q;

	initial
	begin
		if (NW > 255 || DW < 1) $error("rdsl_div: widths out of range.");
	end

	// The divisor is latched at start because the frequency input may move mid-division.
	assign trial = {rem_q[DW-1:0], n_q[NW-1]} - {1'b0, d_q};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q   <= RDSL_D_IDLE;
			rem_q  <= '0;
			n_q    <= '0;
			d_q    <= '0;
			cnt_q  <= 8'h00;
			quot_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (st_q)
				RDSL_D_IDLE:
				begin
					if (start)
					begin
						n_q   <= num;
						d_q   <= den;
						rem_q <= '0;
						cnt_q <= 8'(NW);
						st_q  <= RDSL_D_BUSY;
					end
				end
				RDSL_D_BUSY:
				begin
					if (!trial[DW])
						rem_q <= trial;
					else
						rem_q <= {rem_q[DW-1:0], n_q[NW-1]};
					n_q   <= {n_q[NW-2:0], ~trial[DW]};
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01)
					begin
						quot_q <= {n_q[NW-2:0], ~trial[DW]};
						done_q <= 1'b1;
						st_q   <= RDSL_D_IDLE;
					end
				end
				default: st_q <= RDSL_D_IDLE;
			endcase
		end
	end
endmodule : rdsl_div
`default_nettype wire

// ### rtl/rdsl_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous pins.
// Notes:   Output changes only once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rdsl_sync
	import rdsl_pkg::*;
#(
	parameter int W = 3
)(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] level_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	initial
	begin
		if (W < 1) $error("rdsl_sync: W must be positive.");
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					level_q[g] <= 1'b0;
				else if (s2_q[g] == s3_q[g])
					level_q[g] <= s3_q[g];
			end
		end
	endgenerate
endmodule : rdsl_sync
`default_nettype wire

// ### rtl/rdsl_top.sv
// Purpose: Roll diameter source selection, reset and limiting with APB registers.
// Assumes: Run, winding and input values come from logic on clk; terminals are pins.
// Notes:   Working diameter moves on a fixed tick under the rate limit.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Method codes: 0 fixed, 1 line speed, 2 thickness, 4/5 analog, 7 pulse, 8 serial.
// - Method 0 keeps working diameter equal to initial diameter, no calculation.
// - Method 1 derives diameter from linear speed and output frequency.
// - Method 2 adds twice the thickness per turn pulse winding, subtracts it unwinding.
// - Analog and pulse diameters scale so full scale equals maximum diameter.
// - Method 8 takes diameter from the serial value at register index 0x300C.
// - Every result is clamped to maximum diameter, default 500 mm.
// - Shaft diameter is default initial diameter and lower bound, default 100 mm.
// - Initial source codes: 0 terminals, 2/3 analog, 5 pulse, scaled to maximum.
// - Two select terminals choose shaft, setpoint one, two or three.
// - Setpoints are held between 1 mm and maximum, default 100 mm.
// - Manual reset mode restores initial diameter while reset terminal held, stopped only.
// - Automatic reset mode restores initial diameter after every stop.
// - Change per time limited by rate, default 10.00 mm/s, zero disables.
// - Direction limit blocks decrease when winding and increase when unwinding.
// - Line speed mode holds diameter while speed is below minimum.
// - Line speed mode holds diameter while frequency is at or below minimum.
module rdsl_top
	import rdsl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int AIN_W       = 12
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              drive_running,
	input  wire logic              winding,
	input  wire logic [15:0]       line_speed,
	input  wire logic [15:0]       output_freq,
	input  wire logic [AIN_W-1:0]  analog_input_one,
	input  wire logic [AIN_W-1:0]  analog_input_two,
	input  wire logic [15:0]       pulse_train_input,
	input  wire logic              diam_reset_pin,
	input  wire logic              init_sel_one_pin,
	input  wire logic              init_sel_two_pin,
	input  wire logic              turn_count_pin,
	output var  logic [15:0]       working_diameter,
	output var  logic              calc_frozen
);
	initial
	begin
		if (TICK_CYCLES < 1) $error("rdsl_top: TICK_CYCLES must be positive.");
		if (AIN_W < 1 || AIN_W > 16) $error("rdsl_top: AIN_W out of range.");
	end

	// ************************************************************
	// Register bus.
	// ************************************************************
	rdsl_cfg_t   cfg_q;
	logic [15:0] rd_idx;
	logic        mapped;
	logic        wr_en;

	function automatic logic is_mapped(input logic [15:0] idx);
		case (idx)
			IDX_METHOD, IDX_MAX_D, IDX_SHAFT, IDX_INIT_SRC,
			IDX_SP1, IDX_SP2, IDX_SP3, IDX_RST_MODE,
			IDX_RATE, IDX_DIR_LIM, IDX_MIN_LS, IDX_MIN_F,
			IDX_THICK, IDX_STATUS, IDX_SERIAL_D: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v < lo)
			clamp16 = lo;
		else if (v > hi)
			clamp16 = hi;
		else
			clamp16 = v;
	endfunction : clamp16

	function automatic logic [15:0] scale_fs(input logic [15:0] v, input int fs,
		input logic [15:0] dmax);
		logic [31:0] p;
		p        = 32'(v) * 32'(dmax);
		scale_fs = 16'(p / 32'(fs));
	endfunction : scale_fs

	assign rd_idx  = 16'(paddr >> 2);
	assign mapped  = is_mapped(rd_idx) && (paddr[1:0] == 2'b00);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en   = psel && penable && pwrite && mapped;

	logic method_ok;
	logic src_ok;
	assign method_ok = pwdata[15:0] <= 16'(M_SERIAL) && pwdata[15:0] != 16'h0003
		&& pwdata[15:0] != 16'h0006;
	assign src_ok    = pwdata[15:0] <= 16'(I_PULSE) && pwdata[15:0] != 16'h0001
		&& pwdata[15:0] != 16'h0004;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q.method   <= RST_METHOD;
			cfg_q.max_d    <= RST_MAX_D;
			cfg_q.shaft    <= RST_SHAFT;
			cfg_q.init_src <= RST_INIT_SRC;
			cfg_q.sp1      <= RST_SP;
			cfg_q.sp2      <= RST_SP;
			cfg_q.sp3      <= RST_SP;
			cfg_q.rst_mode <= RST_RST_MODE;
			cfg_q.rate     <= RST_RATE;
			cfg_q.dir_lim  <= RST_DIR_LIM;
			cfg_q.min_ls   <= RST_MIN_LS;
			cfg_q.min_f    <= RST_MIN_F;
			cfg_q.thick    <= RST_THICK;
			cfg_q.serial_d <= RST_SHAFT;
		end
		else if (wr_en)
		begin
			case (rd_idx)
				IDX_METHOD:
					if (!drive_running && method_ok)
						cfg_q.method <= pwdata[15:0];
				IDX_MAX_D:
					if (!drive_running)
						cfg_q.max_d <= clamp16(pwdata[15:0], cfg_q.shaft, 16'hFFFF);
				IDX_SHAFT:
					if (!drive_running)
						cfg_q.shaft <= clamp16(pwdata[15:0], MIN_DIAM, cfg_q.max_d);
				IDX_INIT_SRC:
					if (!drive_running && src_ok)
						cfg_q.init_src <= pwdata[15:0];
				IDX_SP1:      cfg_q.sp1 <= clamp16(pwdata[15:0], MIN_DIAM, cfg_q.max_d);
				IDX_SP2:      cfg_q.sp2 <= clamp16(pwdata[15:0], MIN_DIAM, cfg_q.max_d);
				IDX_SP3:      cfg_q.sp3 <= clamp16(pwdata[15:0], MIN_DIAM, cfg_q.max_d);
				IDX_RST_MODE: cfg_q.rst_mode <= {15'h0000, pwdata[0]};
				IDX_RATE:     cfg_q.rate <= clamp16(pwdata[15:0], 16'h0000, MAX_RATE);
				IDX_DIR_LIM:  cfg_q.dir_lim <= {15'h0000, pwdata[0]};
				IDX_MIN_LS:   cfg_q.min_ls <= pwdata[15:0];
				IDX_MIN_F:    cfg_q.min_f <= pwdata[15:0];
				IDX_THICK:    cfg_q.thick <= pwdata[15:0];
				IDX_SERIAL_D: cfg_q.serial_d <= pwdata[15:0];
				default:      cfg_q.method <= cfg_q.method;
			endcase
		end
	end

	// Read data is captured in the setup phase so it stands in a flip-flop for the access phase.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			case (mapped ? rd_idx : 16'h0000)
				IDX_METHOD:   prdata <= {16'h0000, cfg_q.method};
				IDX_MAX_D:    prdata <= {16'h0000, cfg_q.max_d};
				IDX_SHAFT:    prdata <= {16'h0000, cfg_q.shaft};
				IDX_INIT_SRC: prdata <= {16'h0000, cfg_q.init_src};
				IDX_SP1:      prdata <= {16'h0000, cfg_q.sp1};
				IDX_SP2:      prdata <= {16'h0000, cfg_q.sp2};
				IDX_SP3:      prdata <= {16'h0000, cfg_q.sp3};
				IDX_RST_MODE: prdata <= {16'h0000, cfg_q.rst_mode};
				IDX_RATE:     prdata <= {16'h0000, cfg_q.rate};
				IDX_DIR_LIM:  prdata <= {16'h0000, cfg_q.dir_lim};
				IDX_MIN_LS:   prdata <= {16'h0000, cfg_q.min_ls};
				IDX_MIN_F:    prdata <= {16'h0000, cfg_q.min_f};
				IDX_THICK:    prdata <= {16'h0000, cfg_q.thick};
				IDX_SERIAL_D: prdata <= {16'h0000, cfg_q.serial_d};
				IDX_STATUS:   prdata <= {15'h0000, calc_frozen, working_diameter};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// Terminal inputs.
	// ************************************************************
	logic [3:0] term_q;
	logic       turn_prev_q;
	logic       run_prev_q;
	logic       turn_pulse;
	logic       stop_event;

	rdsl_sync #(
		.W(4)
	) u_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  ({turn_count_pin, diam_reset_pin, init_sel_two_pin, init_sel_one_pin}),
		.level_q (term_q)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			turn_prev_q <= 1'b0;
			run_prev_q  <= 1'b0;
		end
		else
		begin
			turn_prev_q <= term_q[3];
			run_prev_q  <= drive_running;
		end
	end

	assign turn_pulse = term_q[3] && !turn_prev_q;
	assign stop_event = run_prev_q && !drive_running;

	// ************************************************************
	// Initial diameter and source targets.
	// ************************************************************
	logic [15:0] init_raw;
	logic [15:0] init_mm;
	logic [15:0] src_mm;
	logic [15:0] tgt_mm;
	logic [15:0] ls_mm_q;

	always_comb
	begin
		case (cfg_q.init_src[3:0])
			I_AIN1:  init_raw = scale_fs(16'(analog_input_one), AIN_FS, cfg_q.max_d);
			I_AIN2:  init_raw = scale_fs(16'(analog_input_two), AIN_FS, cfg_q.max_d);
			I_PULSE: init_raw = scale_fs(pulse_train_input, PUL_FS, cfg_q.max_d);
			default:
			begin
				case (term_q[1:0])
					2'b01:   init_raw = cfg_q.sp1;
					2'b10:   init_raw = cfg_q.sp2;
					2'b11:   init_raw = cfg_q.sp3;
					default: init_raw = cfg_q.shaft;
				endcase
			end
		endcase
		init_mm = clamp16(init_raw, cfg_q.shaft, cfg_q.max_d);
	end

	always_comb
	begin
		case (cfg_q.method[3:0])
			M_LINE:   src_mm = ls_mm_q;
			M_AIN1:   src_mm = scale_fs(16'(analog_input_one), AIN_FS, cfg_q.max_d);
			M_AIN2:   src_mm = scale_fs(16'(analog_input_two), AIN_FS, cfg_q.max_d);
			M_PULSE:  src_mm = scale_fs(pulse_train_input, PUL_FS, cfg_q.max_d);
			M_SERIAL: src_mm = cfg_q.serial_d;
			default:  src_mm = init_mm;
		endcase
		tgt_mm = clamp16(src_mm, cfg_q.shaft, cfg_q.max_d);
	end

	// ************************************************************
	// Line speed calculation.
	// ************************************************************
	logic [31:0] tick_cnt_q;
	logic        tick;
	logic [31:0] quot;
	logic        div_done;
	logic        ls_start;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tick_cnt_q <= 32'h0000_0000;
		else if (tick)
			tick_cnt_q <= 32'h0000_0000;
		else
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
	end

	assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

	always_comb
	begin
		calc_frozen = (line_speed < cfg_q.min_ls)
			|| (output_freq <= cfg_q.min_f) || (output_freq == 16'h0000);
	end

	assign ls_start = tick && cfg_q.method[3:0] == M_LINE && !calc_frozen;

	rdsl_div #(
		.NW(32),
		.DW(16)
	) u_div (
		.clk    (clk),
		.rst    (rst),
		.start  (ls_start),
		.num    (32'(line_speed) * 32'(LS_GAIN)),
		.den    (output_freq),
		.quot_q (quot),
		.done_q (div_done)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ls_mm_q <= RST_SHAFT;
		else if (div_done)
			ls_mm_q <= (quot > 32'(cfg_q.max_d)) ? cfg_q.max_d : quot[15:0];
	end

	// ************************************************************
	// Working diameter, held with four decimal places of a mm.
	// ************************************************************
	logic [31:0] wd_q;
	logic [31:0] acc_q;
	logic [31:0] lo_i;
	logic [31:0] hi_i;
	logic [31:0] tgt_i;
	logic [31:0] step;
	logic [31:0] th_i;
	logic        do_reset;
	logic        hold;

	assign lo_i  = 32'(cfg_q.shaft) * FRAC;
	assign hi_i  = 32'(cfg_q.max_d) * FRAC;
	assign th_i  = 32'(cfg_q.thick) * THICK_SCALE;
	assign step  = 32'(cfg_q.rate);
	assign tgt_i = (cfg_q.method[3:0] == M_THICK) ? acc_q : 32'(tgt_mm) * FRAC;
	assign do_reset = (cfg_q.rst_mode[0] == 1'b0 && term_q[2] && !drive_running)
		|| (cfg_q.rst_mode[0] == 1'b1 && stop_event);
	assign hold = (cfg_q.method[3:0] == M_LINE && calc_frozen)
		|| (cfg_q.dir_lim[0] && winding && tgt_i < wd_q)
		|| (cfg_q.dir_lim[0] && !winding && tgt_i > wd_q);

	// Thickness turns change the diameter by twice the thickness per turn.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acc_q <= 32'(RST_SHAFT) * FRAC;
		else if (do_reset || cfg_q.method[3:0] != M_THICK)
			acc_q <= 32'(init_mm) * FRAC;
		else if (turn_pulse && winding)
			acc_q <= (acc_q + th_i > hi_i) ? hi_i : acc_q + th_i;
		else if (turn_pulse)
			acc_q <= (acc_q < lo_i + th_i) ? lo_i : acc_q - th_i;
	end

	// A zero rate follows the target every clock; otherwise the step is per tick.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wd_q <= 32'(RST_SHAFT) * FRAC;
		else if (do_reset || cfg_q.method[3:0] == M_FIXED)
			wd_q <= 32'(init_mm) * FRAC;
		else if (hold)
			wd_q <= wd_q;
		else if (cfg_q.rate == 16'h0000)
			wd_q <= tgt_i;
		else if (tick && tgt_i > wd_q)
			wd_q <= (tgt_i - wd_q > step) ? wd_q + step : tgt_i;
		else if (tick && tgt_i < wd_q)
			wd_q <= (wd_q - tgt_i > step) ? wd_q - step : tgt_i;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			working_diameter <= RST_SHAFT;
		else
			working_diameter <= 16'(wd_q / FRAC);
	end
endmodule : rdsl_top
`default_nettype wire

// ### test/rdsl_pins.sv
// Purpose: Terminal model for the select, reset and turn pins.
// Assumes: Commands come from the bench on clk.
// Notes:   A turn pulse lasts six clocks so the pin filter sees it.
`timescale 1ns/1ps
`default_nettype none
module rdsl_pins
(
	input  wire logic       clk,
	input  wire logic       rst_cmd,
	input  wire logic [1:0] sel_cmd,
	input  wire logic       turn_cmd,
	output wire logic       diam_reset_pin,
	output wire logic       init_sel_one_pin,
	output wire logic       init_sel_two_pin,
	output wire logic       turn_count_pin
);
	logic [3:0] cnt_q = 4'h0;
	always @(posedge clk) cnt_q <= turn_cmd ? 4'h6 : cnt_q - {3'h0, cnt_q != 4'h0};
	assign turn_count_pin   = cnt_q != 4'h0;
	assign diam_reset_pin   = rst_cmd;
	assign init_sel_one_pin = sel_cmd[0];
	assign init_sel_two_pin = sel_cmd[1];
endmodule : rdsl_pins
`default_nettype wire

// ### test/rdsl_top_properties.sv
// Purpose: Port-level properties of the roll diameter block.
// Assumes: Zero-wait APB slave; registered diameter output.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module rdsl_top_properties
	import rdsl_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [15:0]       output_freq,
	input wire logic [15:0]       working_diameter,
	input wire logic              calc_frozen
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	ready_in_access_a: assert property (psel && penable |-> pready)
		else $error("access without ready");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access accepted");
	unmapped_zero_a: assert property (psel && penable && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	read_hold_a: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved after access");
	rd_upper_a: assert property (prdata[31:17] == 15'h0)
		else $error("upper read bits set");
	reset_diam_a: assert property ($fell(rst) |-> working_diameter == 16'h64)
		else $error("diameter not shaft after reset");
	freq_zero_frozen_a: assert property (output_freq == 16'h0 |-> calc_frozen)
		else $error("zero frequency not frozen");
endmodule : rdsl_top_properties
bind rdsl_top rdsl_top_properties u_props (.*);
`default_nettype wire

// ### test/rdsl_top_tb.sv
// Purpose: Self-checking bench for the roll diameter block.
// Assumes: Tick shortened to 20 clocks; pins come from the terminal model.
// Notes:   Random values come from an LFSR that starts at 99.
`timescale 1ns/1ps
`default_nettype none
module rdsl_top_tb
	import rdsl_pkg::*;
;
	logic clk = 1'b0;
	logic rst, psel, penable, pwrite, pready, pslverr, drive_running, winding, calc_frozen;
	logic rst_cmd, turn_cmd, diam_reset_pin, init_sel_one_pin, init_sel_two_pin, turn_count_pin;
	logic [1:0] sel_cmd, ofs;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] line_speed, output_freq, pulse_train_input, working_diameter, rd, lf, v;
	logic [11:0] analog_input_one, analog_input_two;
	logic er;
	int err_total, checks;
	logic [15:0] ri [10] = '{IDX_METHOD, IDX_MAX_D, IDX_SHAFT, IDX_INIT_SRC, IDX_SP1,
		IDX_SP2, IDX_SP3, IDX_RST_MODE, IDX_RATE, IDX_DIR_LIM};
	logic [15:0] rv [10] = '{16'h0, 16'h1F4, 16'h64, 16'h0, 16'h64, 16'h64, 16'h64, 16'h0, 16'h3E8, 16'h0};
	logic [15:0] mc [3] = '{16'h4, 16'h5, 16'h7};
	always #12.5 clk = ~clk;
	rdsl_top #(.TICK_CYCLES(20)) dut (.*);
	rdsl_pins u_pins (.*);
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	function automatic logic [15:0] clamp(input logic [31:0] x);
		return x > 32'h1F4 ? 16'h1F4 : (x < 32'h64 ? 16'h64 : x[15:0]);
	endfunction : clamp
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, ofs};
		pwdata <= {16'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata[15:0];
		er = pslverr;
		chk({15'h0, pready}, 16'h1);
		if (pready !== 1'b1)
			end_of_test;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wd_is(input logic [15:0] e);
		int n;
		n = 0;
		while (working_diameter !== e && n < 6000)
		begin
			@(posedge clk);
			n++;
		end
		chk(working_diameter, e);
		if (working_diameter !== e)
			end_of_test;
	endtask : wd_is
	task automatic turn(input int k);
		repeat (k)
		begin
			turn_cmd <= 1'b1;
			@(posedge clk);
			turn_cmd <= 1'b0;
			repeat (20) @(posedge clk);
		end
	endtask : turn
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, drive_running, rst_cmd, turn_cmd, sel_cmd, ofs} = '0;
		winding = 1'b1;
		{paddr, pwdata, line_speed, output_freq, pulse_train_input, analog_input_one, analog_input_two} = '0;
		lf = 16'h63;
		err_total = 0;
		checks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(working_diameter, 16'h64);
		for (int i = 0; i < 10; i++)
		begin
			apb(1'b0, ri[i], 16'h0);
			chk(rd, rv[i]);
		end
		apb(1'b0, 16'h5034, 16'h0);
		chk({15'h0, er}, 16'h1);
		ofs = 2'h2;
		apb(1'b0, IDX_MAX_D, 16'h0);
		ofs = 2'h0;
		chk({15'h0, er}, 16'h1);
		chk(rd, 16'h0);
		$display("register defaults done");
		apb(1'b1, IDX_RATE, 16'h0);
		apb(1'b1, IDX_SP1, 16'h96);
		apb(1'b1, IDX_SP2, 16'hC8);
		apb(1'b1, IDX_SP3, 16'h258);
		apb(1'b0, IDX_SP3, 16'h0);
		chk(rd, 16'h1F4);
		apb(1'b1, IDX_SP3, 16'hFA);
		for (int s = 0; s < 4; s++)
		begin
			sel_cmd <= s[1:0];
			wd_is(16'h64 + 16'h32 * s[15:0]);
		end
		sel_cmd <= 2'h0;
		$display("terminal select done");
		apb(1'b1, IDX_METHOD, 16'h8);
		for (int i = 0; i < 6; i++)
		begin
			lf = nxt(lf);
			v = (i == 0) ? 16'hFFFF : {6'h0, lf[9:0]};
			apb(1'b1, IDX_SERIAL_D, v);
			wd_is(clamp({16'h0, v}));
		end
		apb(1'b1, IDX_METHOD, 16'h3);
		apb(1'b0, IDX_METHOD, 16'h0);
		chk(rd, 16'h8);
		drive_running <= 1'b1;
		apb(1'b1, IDX_METHOD, 16'h0);
		apb(1'b0, IDX_METHOD, 16'h0);
		chk(rd, 16'h8);
		apb(1'b1, IDX_SERIAL_D, 16'h12C);
		wd_is(16'h12C);
		apb(1'b1, IDX_DIR_LIM, 16'h1);
		apb(1'b1, IDX_SERIAL_D, 16'hC8);
		repeat (100) @(posedge clk);
		chk(working_diameter, 16'h12C);
		winding <= 1'b0;
		wd_is(16'hC8);
		apb(1'b1, IDX_DIR_LIM, 16'h0);
		apb(1'b1, IDX_RATE, 16'h2710);
		apb(1'b1, IDX_SERIAL_D, 16'h190);
		repeat (100) @(posedge clk);
		chk({15'h0, working_diameter > 16'hC8 && working_diameter < 16'hD3}, 16'h1);
		wd_is(16'h190);
		apb(1'b1, IDX_RATE, 16'h0);
		$display("serial, direction and rate done");
		drive_running <= 1'b0;
		for (int m = 0; m < 3; m++)
		begin
			lf = nxt(lf);
			v = (m == 0) ? 16'h0FFF : lf;
			analog_input_one <= v[11:0];
			analog_input_two <= v[11:0];
			pulse_train_input <= {1'b0, v[14:0]};
			apb(1'b1, IDX_METHOD, mc[m]);
			wd_is(clamp(m == 2 ? 32'(v[14:0]) * 32'h1F4 / 32'hC350 : 32'(v[11:0]) * 32'h1F4 / 32'hFFF));
		end
		apb(1'b1, IDX_METHOD, 16'h0);
		analog_input_two <= 12'h800;
		apb(1'b1, IDX_INIT_SRC, 16'h3);
		wd_is(16'hFA);
		apb(1'b1, IDX_INIT_SRC, 16'h0);
		apb(1'b1, IDX_THICK, 16'h3E8);
		apb(1'b1, IDX_METHOD, 16'h2);
		wd_is(16'h64);
		drive_running <= 1'b1;
		winding <= 1'b1;
		turn(3);
		wd_is(16'h6A);
		winding <= 1'b0;
		turn(1);
		wd_is(16'h68);
		apb(1'b1, IDX_RST_MODE, 16'h1);
		drive_running <= 1'b0;
		wd_is(16'h64);
		apb(1'b1, IDX_RST_MODE, 16'h0);
		drive_running <= 1'b1;
		winding <= 1'b1;
		turn(1);
		wd_is(16'h66);
		rst_cmd <= 1'b1;
		repeat (50) @(posedge clk);
		chk(working_diameter, 16'h66);
		drive_running <= 1'b0;
		wd_is(16'h64);
		rst_cmd <= 1'b0;
		$display("analog, thickness and reset done");
		line_speed <= 16'h190;
		output_freq <= 16'h6A;
		apb(1'b1, IDX_METHOD, 16'h1);
		drive_running <= 1'b1;
		wd_is(16'hC8);
		output_freq <= 16'h64;
		line_speed <= 16'h320;
		repeat (200) @(posedge clk);
		chk({15'h0, calc_frozen}, 16'h1);
		chk(working_diameter, 16'hC8);
		output_freq <= 16'h6A;
		line_speed <= 16'h13;
		repeat (200) @(posedge clk);
		chk(working_diameter, 16'hC8);
		line_speed <= 16'h14;
		wd_is(16'h64);
		$display("line speed done");
		end_of_test;
	end
endmodule : rdsl_top_tb
`default_nettype wire
